// file: core/src_consts.vh
`ifndef SRC_CONSTS_VH
`define SRC_CONSTS_VH

// register indices on the plain register port
`define SRC_REG_CTRL 3'h0
`define SRC_REG_FMT 3'h1
`define SRC_REG_FUPPER 3'h2
`define SRC_REG_FLOWER 3'h3
`define SRC_REG_CAL 3'h4
`define SRC_REG_STATUS 3'h5
`define SRC_REG_XFER 3'h6

// control register fields
`define SRC_CTRL_WINDOW 0
`define SRC_CTRL_EXPANDED 1
`define SRC_CTRL_INIT_DELAY_DISABLE 2
`define SRC_CTRL_FREQ_SELECT_ENABLE 3

// clock and format register fields
`define SRC_FMT_CSS 0
`define SRC_FMT_CFS_LO 1
`define SRC_FMT_CFS_HI 3

// calibration register fields
`define SRC_CAL_REQ 0
`define SRC_CAL_ACTIVE 1

// status register fields
`define SRC_STAT_BUSY 0
`define SRC_STAT_RUNNING 1

// reset values, the busy pattern and the fine rate limits
`define SRC_BUSY_BYTE 8'h80
`define SRC_FMT_RESET 8'h00
`define SRC_FREQ_RESET 16'hBB80
`define SRC_FREQ_MIN 16'h0FA0
`define SRC_FREQ_MAX 16'hC350

// timing: 200 us compat wait, 384 sample calibration, 20 MHz clock
`define SRC_CLK_HZ 20000000
`define SRC_COMPAT_US 200
`define SRC_COMPAT_CYC ((`SRC_CLK_HZ / 1000000) * `SRC_COMPAT_US)
`define SRC_CAL_SAMPLES 384
`define SRC_SETTLE_TICKS 4

`endif

// file: core/src_rate_ctrl.v
`timescale 1ns/100ps
`include "src_consts.vh"

// Functional notes
// - Legacy set changes rate by window or format write, expanded set by the frequency select pair when freq_select_enable is set.
// - Host writes are dropped without effect while resynchronisation runs.
// - Host reads return 80h until resynchronisation finishes.
// - Divide or source changes written in one cycle apply on the fly in both sets.
// - An on-the-fly change with the window closed shows the busy pattern for the 200 us compat wait plus four sample ticks at the new rate.
// - With init delay disabled the compatibility wait is skipped.
// - The generator derives 46,001 distinct rates (4000..50000 Hz) from the single clock.
// - The calibration flag stays high while calibration runs.
// - A transfer enabled during calibration waits until calibration ends.
module src_rate_ctrl (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // register port
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // rate generator outputs
  output wire sample_tick_o,
  output wire [15:0] rate_hz_o,
  output wire busy_o,
  output wire cal_active_o,
  output wire xfer_run_o
);

  localparam ST_IDLE = 2'h0;
  localparam ST_COMPAT = 2'h1;
  localparam ST_SETTLE = 2'h2;

  // integer forms of the timing counts, cut to counter width on purpose
  localparam integer COMPAT_INT = `SRC_COMPAT_CYC;
  localparam integer CAL_INT = `SRC_CAL_SAMPLES;
  localparam integer SETTLE_INT = `SRC_SETTLE_TICKS;
  localparam integer CLK_INT = `SRC_CLK_HZ;
  localparam [13:0] COMPAT_CYC = COMPAT_INT[13:0];
  localparam [8:0] CAL_LEN = CAL_INT[8:0];
  localparam [2:0] SETTLE_LEN = SETTLE_INT[2:0];
  localparam [24:0] CLK_HZ = CLK_INT[24:0];

  // legacy divide table in Hz; the alternate source halves each entry
  localparam [15:0] RATE_DIV0 = 16'h1F40;
  localparam [15:0] RATE_DIV1 = 16'h3E80;
  localparam [15:0] RATE_DIV2 = 16'h7D00;
  localparam [15:0] RATE_DIV3 = 16'hAC44;
  localparam [15:0] RATE_DIV4 = 16'h5622;
  localparam [15:0] RATE_DIV5 = 16'h2B11;
  localparam [15:0] RATE_DIV6 = 16'hBB80;

  // software-visible control state
  reg window_q;
  reg expanded_q;
  reg init_delay_disable_q;
  reg freq_select_enable_q;
  reg css_q;
  reg [2:0] cfs_q;
  reg [7:0] fupper_q;
  reg [7:0] flower_q;
  reg cal_req_q;
  reg cal_first_q;
  reg cal_active_q;
  reg [8:0] cal_cnt_q;
  reg xfer_en_q;

  // resync sequencer and rate generator state
  reg [1:0] state_q;
  reg [13:0] wait_q;
  reg [2:0] settle_q;
  reg [24:0] acc_q;
  reg tick_q;
  reg [15:0] rate_q;

  // decoded strobes and combinational rate
  wire busy;
  wire wr_ok;
  wire fmt_change;
  wire freq_write;
  wire [15:0] fine_rate;
  reg [15:0] legacy_rate;
  reg [15:0] rate_d;
  wire wr_ctrl;
  wire wr_fmt;
  wire wr_fine;
  wire fine_ok;
  wire cal_start;
  wire compat_done;
  wire settle_done;
  wire cal_done;
  wire [24:0] acc_sum;

  // one busy flag drives both write gating and read forcing
  assign busy = (state_q != ST_IDLE);
  assign wr_ok = wr_i & ~busy;
  assign busy_o = busy;
  assign cal_active_o = cal_active_q;
  assign sample_tick_o = tick_q;
  assign rate_hz_o = rate_q;
  // transfers held back until calibration has ended
  assign xfer_run_o = xfer_en_q & ~cal_active_q;

  // per-register write enables, all behind the busy gate
  assign wr_ctrl = wr_ok && (addr_i == `SRC_REG_CTRL);
  assign wr_fmt = wr_ok && (addr_i == `SRC_REG_FMT);
  assign wr_fine = wr_ok && ((addr_i == `SRC_REG_FUPPER) || (addr_i == `SRC_REG_FLOWER));
  // the 1 Hz select pair is live only in the expanded set with freq_select_enable set
  assign fine_ok = expanded_q && freq_select_enable_q;

  // a single write that moves divide or source starts a resync
  assign fmt_change = wr_fmt &&
    ((wdata_i[`SRC_FMT_CSS] != css_q) ||
     (wdata_i[`SRC_FMT_CFS_HI:`SRC_FMT_CFS_LO] != cfs_q));
  // fine select writes count only while the pair is live
  assign freq_write = wr_fine && fine_ok;

  // calibration starts when the window closes with a request, or the first time after reset
  assign cal_start = wr_ctrl && window_q && !wdata_i[`SRC_CTRL_WINDOW] && (cal_req_q || cal_first_q);
  // end points of the compat wait, the settle count and the calibration count
  assign compat_done = (wait_q == COMPAT_CYC - 14'h0001);
  assign settle_done = (settle_q == SETTLE_LEN - 3'h1);
  assign cal_done = (cal_cnt_q == CAL_LEN - 9'h001);
  // running accumulator sum, shared by the compare and the update
  assign acc_sum = acc_q + {9'h000, rate_q};

  // fine rate clamped to the generator span of 4000..50000 Hz
  assign fine_rate = ({fupper_q, flower_q} < `SRC_FREQ_MIN) ? `SRC_FREQ_MIN :
    (({fupper_q, flower_q} > `SRC_FREQ_MAX) ? `SRC_FREQ_MAX : {fupper_q, flower_q});

  // legacy divide table, halved for the alternate source
  always @* begin
    case (cfs_q)
      3'h0: legacy_rate = RATE_DIV0;
      3'h1: legacy_rate = RATE_DIV1;
      3'h2: legacy_rate = RATE_DIV2;
      3'h3: legacy_rate = RATE_DIV3;
      3'h4: legacy_rate = RATE_DIV4;
      3'h5: legacy_rate = RATE_DIV5;
      3'h6: legacy_rate = RATE_DIV6;
      default: legacy_rate = RATE_DIV1;
    endcase
    if (css_q) begin
      legacy_rate = {1'b0, legacy_rate[15:1]};
    end
    // expanded set with freq_select_enable uses the 1 Hz select pair
    rate_d = (expanded_q && freq_select_enable_q) ? fine_rate : legacy_rate;
  end

  // control registers, written only when not busy
  always @(posedge clk_i) begin
    if (rst_i) begin
      window_q <= 1'b0;
      expanded_q <= 1'b0;
      init_delay_disable_q <= 1'b0;
      freq_select_enable_q <= 1'b0;
      css_q <= 1'b0;
      cfs_q <= 3'h0;
      fupper_q <= 8'hBB;
      flower_q <= 8'h80;
      cal_req_q <= 1'b0;
      xfer_en_q <= 1'b0;
    end else if (wr_ok) begin
      case (addr_i)
        `SRC_REG_CTRL: begin
          window_q <= wdata_i[`SRC_CTRL_WINDOW];
          expanded_q <= wdata_i[`SRC_CTRL_EXPANDED];
          init_delay_disable_q <= wdata_i[`SRC_CTRL_INIT_DELAY_DISABLE];
          freq_select_enable_q <= wdata_i[`SRC_CTRL_FREQ_SELECT_ENABLE];
        end
        `SRC_REG_FMT: begin
          css_q <= wdata_i[`SRC_FMT_CSS];
          cfs_q <= wdata_i[`SRC_FMT_CFS_HI:`SRC_FMT_CFS_LO];
        end
        `SRC_REG_FUPPER: begin
          if (expanded_q && freq_select_enable_q) begin
            fupper_q <= wdata_i;
          end
        end
        `SRC_REG_FLOWER: begin
          if (expanded_q && freq_select_enable_q) begin
            flower_q <= wdata_i;
          end
        end
        `SRC_REG_CAL: cal_req_q <= wdata_i[`SRC_CAL_REQ];
        `SRC_REG_XFER: xfer_en_q <= wdata_i[0];
        default: ;
      endcase
    end
  end

  // resync sequencer: optional compat wait, then settle over sample ticks
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      wait_q <= 14'h0000;
      settle_q <= 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (fmt_change) begin
            settle_q <= 3'h0;
            if (window_q || init_delay_disable_q) begin
              state_q <= ST_SETTLE;
            end else begin
              wait_q <= 14'h0000;
              state_q <= ST_COMPAT;
            end
          end else if (freq_write) begin
            settle_q <= 3'h0;
            state_q <= ST_SETTLE;
          end
        end
        ST_COMPAT: begin
          if (compat_done) begin
            state_q <= ST_SETTLE;
          end else begin
            wait_q <= wait_q + 14'h0001;
          end
        end
        ST_SETTLE: begin
          // stable once several ticks at the new rate have passed
          if (tick_q) begin
            if (settle_done) begin
              state_q <= ST_IDLE;
            end else begin
              settle_q <= settle_q + 3'h1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // fractional accumulator produces one tick per sample at rate_q
  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= 25'h0000000;
      tick_q <= 1'b0;
      rate_q <= `SRC_FREQ_RESET;
    end else begin
      rate_q <= rate_d;
      if (acc_sum >= CLK_HZ) begin
        acc_q <= acc_sum - CLK_HZ;
        tick_q <= 1'b1;
      end else begin
        acc_q <= acc_sum;
        tick_q <= 1'b0;
      end
    end
  end

  // calibration starts when the window closes with a request, or first time
  always @(posedge clk_i) begin
    if (rst_i) begin
      cal_first_q <= 1'b1;
      cal_active_q <= 1'b0;
      cal_cnt_q <= 9'h000;
    end else if (cal_start) begin
      cal_first_q <= 1'b0;
      cal_active_q <= 1'b1;
      cal_cnt_q <= 9'h000;
    end else if (cal_active_q && tick_q) begin
      if (cal_done) begin
        cal_active_q <= 1'b0;
      end else begin
        cal_cnt_q <= cal_cnt_q + 9'h001;
      end
    end
  end

  // read data one cycle later, forced to the busy byte during resync
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (busy) begin
        rdata_o <= `SRC_BUSY_BYTE;
      end else begin
        case (addr_i)
          `SRC_REG_CTRL: rdata_o <= {4'h0, freq_select_enable_q, init_delay_disable_q, expanded_q, window_q};
          `SRC_REG_FMT: rdata_o <= {4'h0, cfs_q, css_q};
          `SRC_REG_FUPPER: rdata_o <= fupper_q;
          `SRC_REG_FLOWER: rdata_o <= flower_q;
          `SRC_REG_CAL: rdata_o <= {6'h00, cal_active_q, cal_req_q};
          `SRC_REG_STATUS: rdata_o <= {6'h00, xfer_run_o, 1'b0};
          `SRC_REG_XFER: rdata_o <= {7'h00, xfer_en_q};
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end

endmodule

// file: dv/src_rate_ctrl_chk.sv
`timescale 1ns/100ps
module src_rate_ctrl_chk (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // register port
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  // rate outputs
  input wire sample_tick_o,
  input wire [15:0] rate_hz_o,
  input wire busy_o,
  input wire cal_active_o,
  input wire xfer_run_o
);
  int busy_n;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // busy length counter; worst case is compat wait plus four ticks at 4 kHz
  always @(posedge clk_i) begin
    if (rst_i || !busy_o) busy_n <= 0;
    else busy_n <= busy_n + 1;
  end
  sequence s_busy_rd;
    rd_i && busy_o;
  endsequence
  sequence s_busy_xfer_wr;
    busy_o && wr_i && addr_i == 3'h6 && !cal_active_o ##1 !cal_active_o;
  endsequence
  chk_busy_read: assert property (s_busy_rd |=> rdata_o == 8'h80) else $error("busy read wrong");
  chk_wr_drop: assert property (s_busy_xfer_wr |-> $stable(xfer_run_o)) else $error("busy write took");
  chk_busy_cause: assert property ($rose(busy_o) |-> $past(wr_i)) else $error("busy without write");
  chk_busy_len: assert property (busy_n < 24100) else $error("busy too long");
  chk_cal_cause: assert property ($rose(cal_active_o) |-> $past(wr_i && addr_i == 3'h0)) else $error("cal cause");
  chk_xfer_gate: assert property (cal_active_o |-> !xfer_run_o) else $error("xfer during cal");
  chk_rate_range: assert property (rate_hz_o >= 16'h0FA0 && rate_hz_o <= 16'hC350) else $error("rate range");
  chk_tick_pulse: assert property (sample_tick_o |=> !sample_tick_o) else $error("tick too long");
endmodule
bind src_rate_ctrl src_rate_ctrl_chk i_chk (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .sample_tick_o, .rate_hz_o, .busy_o, .cal_active_o, .xfer_run_o);

// file: dv/src_host_model.sv
`timescale 1ns/100ps
module src_host_model (
  // clock
  input wire clk_i,
  // register port
  output logic [2:0] addr_o = 3'h0,
  output logic [7:0] wdata_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  input wire [7:0] rdata_i
);
  // one-cycle write; divide and source always travel in the same byte
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    #1;
  endtask
  // read data taken in the cycle after the strobe; it then holds until the next read
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask
  // poll until the busy pattern goes; n counts cycles, bounded against a hang
  task automatic poll(input logic [2:0] a, output int n, output logic [7:0] d);
    n = 0;
    d = 8'h80;
    while (d === 8'h80 && n < 40000) begin
      rd_reg(a, d);
      n = n + 2;
    end
  endtask
endmodule

// file: dv/src_rate_ctrl_bench.sv
`timescale 1ns/100ps
`include "src_consts.vh"
module src_rate_ctrl_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, d;
  logic wr_i, rd_i, sample_tick_o, busy_o, cal_active_o, xfer_run_o;
  logic [15:0] rate_hz_o;
  int mismatches = 0;
  int n_checks = 0;
  int n;
  always #25 clk_i = ~clk_i;
  src_rate_ctrl i_dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sample_tick_o, .rate_hz_o,
    .busy_o, .cal_active_o, .xfer_run_o);
  src_host_model i_host (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a poll that runs out is a hang: report at once
  task automatic ready;
    i_host.poll(`SRC_REG_CTRL, n, d);
    if (n >= 40000) begin
      mismatches++;
      results;
    end
  endtask
  task automatic t_reset;
    check("busy", busy_o, 1'b0);
    i_host.wr_reg(`SRC_REG_FUPPER, 8'h1F);
    i_host.rd_reg(3'h7, d);
    check("unmapped", d, 8'h00);
    check("legacy rate", rate_hz_o, 16'h1F40);
    i_host.rd_reg(`SRC_REG_FUPPER, d);
    check("fine refused", d, `SRC_FREQ_RESET >> 8);
    $display("reset test done");
  endtask
  task automatic t_onfly;
    i_host.wr_reg(`SRC_REG_FMT, 8'h02);
    check("busy", busy_o, 1'b1);
    i_host.wr_reg(`SRC_REG_XFER, 8'h01);
    i_host.rd_reg(`SRC_REG_CTRL, d);
    check("busy read", d, `SRC_BUSY_BYTE);
    ready;
    check("compat wait", n >= 3990, 1'b1);
    check("dropped", xfer_run_o, 1'b0);
    i_host.rd_reg(`SRC_REG_FMT, d);
    check("fmt", d, 8'h02);
    i_host.wr_reg(`SRC_REG_XFER, 8'h01);
    check("xfer", xfer_run_o, 1'b1);
    $display("on the fly test done");
  endtask
  task automatic t_init_delay_disable;
    i_host.wr_reg(`SRC_REG_CTRL, 8'h04);
    // a fast target rate keeps the settle well under the compat wait
    i_host.wr_reg(`SRC_REG_FMT, 8'h0C);
    ready;
    check("no compat", n < `SRC_COMPAT_CYC, 1'b1);
    check("ctrl", d, 8'h04);
    $display("init delay test done");
  endtask
  // upper, lower, then both clamp edges; each byte resyncs on its own
  task automatic t_fine;
    i_host.wr_reg(`SRC_REG_CTRL, 8'h0E);
    i_host.wr_reg(`SRC_REG_FUPPER, 8'h1F);
    ready;
    i_host.wr_reg(`SRC_REG_FLOWER, 8'h40);
    ready;
    check("fine", rate_hz_o, 16'h1F40);
    i_host.wr_reg(`SRC_REG_FUPPER, 8'hFF);
    ready;
    check("max", rate_hz_o, `SRC_FREQ_MAX);
    i_host.wr_reg(`SRC_REG_FUPPER, 8'h00);
    ready;
    check("min", rate_hz_o, `SRC_FREQ_MIN);
    $display("fine rate test done");
  endtask
  // window path: one format write, resync without compat wait, calibration on close
  task automatic t_window;
    i_host.wr_reg(`SRC_REG_CTRL, 8'h01);
    i_host.wr_reg(`SRC_REG_CAL, 8'h01);
    i_host.wr_reg(`SRC_REG_FMT, 8'h0D);
    check("busy", busy_o, 1'b1);
    ready;
    check("window resync", n < `SRC_COMPAT_CYC, 1'b1);
    i_host.rd_reg(`SRC_REG_FMT, d);
    check("fmt", d, 8'h0D);
    i_host.wr_reg(`SRC_REG_CTRL, 8'h00);
    check("cal active", cal_active_o, 1'b1);
    check("xfer held", xfer_run_o, 1'b0);
    i_host.rd_reg(`SRC_REG_CAL, d);
    check("cal flag", d, 8'h03);
    $display("window test done");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    // divide 0 from the primary source is the running rate once reset lets go
    check("rate", rate_hz_o, 16'h1F40);
    t_reset;
    t_onfly;
    t_init_delay_disable;
    t_fine;
    t_window;
    results;
  end
endmodule
